// ==== inc/pcm_consts.vh ====
`ifndef PCM_CONSTS_VH
`define PCM_CONSTS_VH

// Clock rate and times in their own units
`define PCM_CLK_HZ 10000000
`define PCM_LONG_MS 2000
`define PCM_IDLE_S 60
`define PCM_DEBOUNCE_MS 20
`define PCM_ALT_MS 2000

// Register byte offsets
`define PCM_OFF_CTRL 8'h00
`define PCM_OFF_STATUS 8'h04
`define PCM_OFF_ADDR 8'h08
`define PCM_OFF_LABEL 8'h0C
`define PCM_OFF_CAL 8'h10
`define PCM_OFF_DISP 8'h14

// Control register bits
`define PCM_CTRL_BLANK 0
`define PCM_CTRL_CAL_DUE 1
`define PCM_CTRL_SER_DUE 2

// Calibration register bits; zero value sits in bits 31:16
`define PCM_CAL_ZERO 0
`define PCM_CAL_SPAN_OK 1
`define PCM_CAL_SPAN_FAIL 2

// Reset values
`define PCM_ADDR_RST 8'h01
`define PCM_LABEL_RST 18'h00000

// Station address limits, digit and character ceilings
`define PCM_ADDR_MIN 10'h001
`define PCM_ADDR_MAX 10'h0F7
`define PCM_DIG_MAX 6'h09
`define PCM_CHR_MAX 6'h23

// Menu states, also used as display codes; the last two are display codes only
`define PCM_ST_NORMAL 4'h0
`define PCM_ST_HOLD 4'h1
`define PCM_ST_TOP 4'h2
`define PCM_ST_BUS 4'h3
`define PCM_ST_ADDR_SHOW 4'h4
`define PCM_ST_ADDR_EDIT 4'h5
`define PCM_ST_ADDR_DONE 4'h6
`define PCM_ST_XMT 4'h7
`define PCM_ST_LBL_EDIT 4'h8
`define PCM_ST_LBL_DONE 4'h9
`define PCM_DISP_CAL 4'hA
`define PCM_DISP_SER 4'hB

// Menu item indices
`define PCM_TOP_TITLE 3'h0
`define PCM_TOP_BUS 3'h1
`define PCM_TOP_XMT 3'h3
`define PCM_TOP_LAST 3'h6
`define PCM_SUB_TITLE 3'h0
`define PCM_BUS_ADDR 3'h1
`define PCM_BUS_LAST 3'h1
`define PCM_XMT_BLANK 3'h1
`define PCM_XMT_LABEL 3'h2
`define PCM_XMT_LAST 3'h2

`endif

// ==== hdl/pcm_press_filter.v ====
`timescale 1ns/10ps
`include "pcm_consts.vh"

module pcm_press_filter #(
	parameter DEB_CYC = `PCM_DEBOUNCE_MS * (`PCM_CLK_HZ / 1000),
	parameter LONG_CYC = `PCM_LONG_MS * (`PCM_CLK_HZ / 1000)
) (
	input wire clock,
	input wire reset_n,
	input wire buttonRaw,
	output reg pressStart,
	output reg longReached,
	output reg shortPress,
	output reg longPress
);

	reg sync1_q;
	reg sync2_q;
	reg stable_q;
	reg isLong_q;
	reg [31:0] debCnt_q;
	reg [31:0] holdCnt_q;
	wire flip;

	assign flip = (sync2_q != stable_q) && (debCnt_q == DEB_CYC - 1);

	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			stable_q <= 1'b0;
			isLong_q <= 1'b0;
			debCnt_q <= 32'h00000000;
			holdCnt_q <= 32'h00000000;
			pressStart <= 1'b0;
			longReached <= 1'b0;
			shortPress <= 1'b0;
			longPress <= 1'b0;
		end else begin
			sync1_q <= buttonRaw;
			sync2_q <= sync1_q;
			pressStart <= 1'b0;
			longReached <= 1'b0;
			shortPress <= 1'b0;
			longPress <= 1'b0;
			if (sync2_q == stable_q || flip) begin
				debCnt_q <= 32'h00000000;
			end else begin
				debCnt_q <= debCnt_q + 32'h00000001;
			end
			if (flip) begin
				stable_q <= sync2_q;
				if (sync2_q) begin
					pressStart <= 1'b1;
					holdCnt_q <= 32'h00000000;
					isLong_q <= 1'b0;
				end else begin
					// Classified at release against the threshold
					longPress <= isLong_q;
					shortPress <= !isLong_q;
				end
			end else if (stable_q && !isLong_q) begin
				holdCnt_q <= holdCnt_q + 32'h00000001;
				if (holdCnt_q == LONG_CYC - 1) begin
					isLong_q <= 1'b1;
					longReached <= 1'b1;
				end
			end
		end
	end

endmodule // pcm_press_filter

// ==== hdl/pcm_menu_ctrl.v ====
`timescale 1ns/10ps
`include "pcm_consts.vh"

// What this block does
// - Accept station address only 1 to 247
// - One idle minute leaves level, discarding edits
// - Hold two seconds shows prompt, release opens menu
// - Short press steps circular title plus six items
// - Long press on title returns to normal
// - Minus titles exit to higher level on long
// - Long on bus item opens bus submenu
// - Long shows address; short returns unchanged
// - Edit digits upward from least, long moves on
// - After third digit show address; short returns
// - Long on bus title returns to bus item
// - Long on transmitter item opens its submenu
// - Blanking item enables minute blanking, press restores
// - Label item edits three alphanumeric characters
// - Alternate calibration and service codes with reading
// - Zero result held until span succeeds
// - Aborted or rejected span marks calibration unreliable
module pcm_menu_ctrl #(
	parameter DEB_CYC = `PCM_DEBOUNCE_MS * (`PCM_CLK_HZ / 1000),
	parameter LONG_CYC = `PCM_LONG_MS * (`PCM_CLK_HZ / 1000),
	parameter IDLE_CYC = `PCM_IDLE_S * `PCM_CLK_HZ,
	parameter ALT_CYC = `PCM_ALT_MS * (`PCM_CLK_HZ / 1000)
) (
	input wire clock,
	input wire reset_n,
	input wire buttonRaw,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	output reg [3:0] dispCode,
	output reg [2:0] dispItem,
	output reg [17:0] dispValue,
	output reg [1:0] dispDigit,
	output reg dispBlank,
	output reg configActive,
	output reg [7:0] busAddress,
	output reg [17:0] locationLabel,
	output reg nvCommit,
	output reg [15:0] nvZeroValue,
	output reg calUnreliable
);

	localparam NORMAL = `PCM_ST_NORMAL, HOLD = `PCM_ST_HOLD;
	localparam TOP = `PCM_ST_TOP, BUS = `PCM_ST_BUS;
	localparam ADDR_SHOW = `PCM_ST_ADDR_SHOW, ADDR_EDIT = `PCM_ST_ADDR_EDIT;
	localparam ADDR_DONE = `PCM_ST_ADDR_DONE, XMT = `PCM_ST_XMT;
	localparam LBL_EDIT = `PCM_ST_LBL_EDIT, LBL_DONE = `PCM_ST_LBL_DONE;

	wire pressStart, longReached, shortPress, longPress, anyPress;
	wire idleHit, altHit, apbWr, apbSetup;
	wire [5:0] digMax;
	wire [17:0] bumped, addrDigits;
	wire [9:0] editBin;
	wire [2:0] itemLast, itemNext;
	reg [3:0] state_q, dispCode_d;
	reg [2:0] item_q;
	reg [1:0] digit_q, phase_q;
	reg [17:0] edit_q;
	reg [31:0] idleCnt_q, altCnt_q, rdata_d;
	reg blankEn_q, calDue_q, serDue_q, zeroPending_q, rdErr_d;
	reg [15:0] zeroTmp_q;

	function [17:0] toDigits;
		input [7:0] bin;
		reg [7:0] d0;
		reg [7:0] d1;
		reg [7:0] d2;
		begin
			d0 = bin % 8'h0A;
			d1 = (bin / 8'h0A) % 8'h0A;
			d2 = bin / 8'h64;
			toDigits = {d2[5:0], d1[5:0], d0[5:0]};
		end
	endfunction

	pcm_press_filter #(
		.DEB_CYC(DEB_CYC),
		.LONG_CYC(LONG_CYC)
	) uPress (
		.clock(clock),
		.reset_n(reset_n),
		.buttonRaw(buttonRaw),
		.pressStart(pressStart),
		.longReached(longReached),
		.shortPress(shortPress),
		.longPress(longPress)
	);

	assign anyPress = pressStart | shortPress | longPress;
	assign idleHit = (idleCnt_q == IDLE_CYC - 1);
	assign altHit = (altCnt_q == ALT_CYC - 1);
	assign apbSetup = psel & ~penable;
	assign apbWr = psel & penable & pwrite & pready;
	assign addrDigits = toDigits(busAddress);
	assign editBin = edit_q[17:12] * 10'h064 + edit_q[11:6] * 10'h00A
		+ {4'h0, edit_q[5:0]};
	assign digMax = (state_q == LBL_EDIT) ? `PCM_CHR_MAX : `PCM_DIG_MAX;
	assign itemLast = (state_q == TOP) ? `PCM_TOP_LAST :
		(state_q == BUS) ? `PCM_BUS_LAST : `PCM_XMT_LAST;
	assign itemNext = (item_q == itemLast) ? 3'h0 : item_q + 3'h1;

	// Selected digit steps up and wraps to zero past its ceiling
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : gDigit
			wire [5:0] cur;
			assign cur = edit_q[6 * g + 5:6 * g];
			assign bumped[6 * g + 5:6 * g] = (digit_q != g) ? cur :
				(cur >= digMax) ? 6'h00 : cur + 6'h01;
		end
	endgenerate

	// Menu walk, timeouts, settings and calibration bookkeeping
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= NORMAL;
			item_q <= 3'h0;
			digit_q <= 2'h0;
			edit_q <= 18'h00000;
			idleCnt_q <= 32'h00000000;
			blankEn_q <= 1'b0;
			calDue_q <= 1'b0;
			serDue_q <= 1'b0;
			zeroPending_q <= 1'b0;
			zeroTmp_q <= 16'h0000;
			busAddress <= `PCM_ADDR_RST;
			locationLabel <= `PCM_LABEL_RST;
			nvCommit <= 1'b0;
			nvZeroValue <= 16'h0000;
			calUnreliable <= 1'b0;
		end else begin
			nvCommit <= 1'b0;
			if (anyPress || (idleHit && state_q != NORMAL)) begin
				idleCnt_q <= 32'h00000000;
			end else if (!idleHit) begin
				idleCnt_q <= idleCnt_q + 32'h00000001;
			end
			if (apbWr) begin
				case (paddr)
					`PCM_OFF_CTRL: begin
						blankEn_q <= pwdata[`PCM_CTRL_BLANK];
						calDue_q <= pwdata[`PCM_CTRL_CAL_DUE];
						serDue_q <= pwdata[`PCM_CTRL_SER_DUE];
					end
					`PCM_OFF_ADDR: begin
						if (pwdata[7:0] != 8'h00 && pwdata[7:0] <= 8'hF7 &&
							pwdata[31:8] == 24'h000000) begin
							busAddress <= pwdata[7:0];
						end
					end
					`PCM_OFF_LABEL: locationLabel <= pwdata[17:0];
					`PCM_OFF_CAL: begin
						if (pwdata[`PCM_CAL_ZERO]) begin
							zeroTmp_q <= pwdata[31:16];
							zeroPending_q <= 1'b1;
						end
						if (pwdata[`PCM_CAL_SPAN_OK]) begin
							nvCommit <= 1'b1;
							if (zeroPending_q) begin
								nvZeroValue <= zeroTmp_q;
							end
							zeroPending_q <= 1'b0;
							calUnreliable <= 1'b0;
						end else if (pwdata[`PCM_CAL_SPAN_FAIL]) begin
							calUnreliable <= 1'b1;
						end
					end
					default: ;
				endcase
			end
			if (idleHit && state_q != NORMAL) begin
				// Leave one level; edits in progress are dropped
				case (state_q)
					BUS: begin
						state_q <= TOP;
						item_q <= `PCM_TOP_BUS;
					end
					XMT: begin
						state_q <= TOP;
						item_q <= `PCM_TOP_XMT;
					end
					ADDR_SHOW, ADDR_EDIT, ADDR_DONE: begin
						state_q <= BUS;
						item_q <= `PCM_BUS_ADDR;
					end
					LBL_EDIT, LBL_DONE: begin
						state_q <= XMT;
						item_q <= `PCM_XMT_LABEL;
					end
					default: begin
						state_q <= NORMAL;
						item_q <= 3'h0;
					end
				endcase
			end else begin
				case (state_q)
					NORMAL: if (longReached) state_q <= HOLD;
					HOLD: begin
						if (longPress || shortPress) begin
							state_q <= TOP;
							item_q <= `PCM_TOP_TITLE;
						end
					end
					TOP: begin
						if (shortPress) begin
							item_q <= itemNext;
						end else if (longPress) begin
							if (item_q == `PCM_TOP_TITLE) begin
								state_q <= NORMAL;
							end else if (item_q == `PCM_TOP_BUS) begin
								state_q <= BUS;
								item_q <= `PCM_SUB_TITLE;
							end else if (item_q == `PCM_TOP_XMT) begin
								state_q <= XMT;
								item_q <= `PCM_SUB_TITLE;
							end
						end
					end
					BUS: begin
						if (shortPress) begin
							item_q <= itemNext;
						end else if (longPress) begin
							if (item_q == `PCM_SUB_TITLE) begin
								state_q <= TOP;
								item_q <= `PCM_TOP_BUS;
							end else begin
								state_q <= ADDR_SHOW;
							end
						end
					end
					ADDR_SHOW: begin
						if (shortPress) begin
							state_q <= BUS;
						end else if (longPress) begin
							state_q <= ADDR_EDIT;
							edit_q <= addrDigits;
							digit_q <= 2'h0;
						end
					end
					ADDR_EDIT, LBL_EDIT: begin
						if (shortPress) begin
							edit_q <= bumped;
						end else if (longPress) begin
							if (digit_q != 2'h2) begin
								digit_q <= digit_q + 2'h1;
							end else if (state_q == LBL_EDIT) begin
								state_q <= LBL_DONE;
								locationLabel <= edit_q;
							end else begin
								state_q <= ADDR_DONE;
								if (editBin >= `PCM_ADDR_MIN &&
									editBin <= `PCM_ADDR_MAX) begin
									busAddress <= editBin[7:0];
								end
							end
						end
					end
					ADDR_DONE: if (shortPress) state_q <= BUS;
					XMT: begin
						if (shortPress) begin
							item_q <= itemNext;
						end else if (longPress) begin
							if (item_q == `PCM_SUB_TITLE) begin
								state_q <= TOP;
								item_q <= `PCM_TOP_XMT;
							end else if (item_q == `PCM_XMT_BLANK) begin
								blankEn_q <= 1'b1;
							end else begin
								state_q <= LBL_EDIT;
								edit_q <= locationLabel;
								digit_q <= 2'h0;
							end
						end
					end
					LBL_DONE: if (shortPress) state_q <= XMT;
					default: state_q <= NORMAL;
				endcase
			end
		end
	end

	// Reading, calibration and service codes take turns in normal mode
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			altCnt_q <= 32'h00000000;
			phase_q <= 2'h0;
		end else if (altHit) begin
			altCnt_q <= 32'h00000000;
			phase_q <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
		end else begin
			altCnt_q <= altCnt_q + 32'h00000001;
		end
	end

	always @* begin
		dispCode_d = state_q;
		if (state_q == NORMAL) begin
			if (phase_q == 2'h1 && calDue_q) begin
				dispCode_d = `PCM_DISP_CAL;
			end else if (phase_q == 2'h2 && serDue_q) begin
				dispCode_d = `PCM_DISP_SER;
			end
		end
	end

	always @* begin
		rdata_d = 32'h00000000;
		rdErr_d = 1'b0;
		case (paddr)
			`PCM_OFF_CTRL: rdata_d = {29'h00000000, serDue_q, calDue_q,
				blankEn_q};
			`PCM_OFF_STATUS: rdata_d = {20'h00000, calUnreliable,
				zeroPending_q, dispBlank, digit_q, item_q, state_q};
			`PCM_OFF_ADDR: rdata_d = {24'h000000, busAddress};
			`PCM_OFF_LABEL: rdata_d = {14'h0000, locationLabel};
			`PCM_OFF_CAL: rdata_d = {zeroTmp_q, 13'h0000, calUnreliable,
				1'b0, zeroPending_q};
			`PCM_OFF_DISP: rdata_d = {9'h000, dispBlank, dispCode,
				dispDigit, dispValue[15:0]};
			default: rdErr_d = 1'b1;
		endcase
	end

	// Answer in the access cycle right after setup, no wait states
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
			dispCode <= NORMAL;
			dispItem <= 3'h0;
			dispValue <= 18'h00000;
			dispDigit <= 2'h0;
			dispBlank <= 1'b0;
			configActive <= 1'b0;
		end else begin
			pready <= apbSetup;
			pslverr <= apbSetup & rdErr_d;
			if (apbSetup && !pwrite) begin
				prdata <= rdata_d;
			end
			dispCode <= dispCode_d;
			dispItem <= item_q;
			dispDigit <= digit_q;
			dispValue <= (state_q == ADDR_EDIT || state_q == ADDR_DONE ||
				state_q == LBL_EDIT || state_q == LBL_DONE) ? edit_q :
				addrDigits;
			// Blanking only in normal mode; a menu timeout is no blank
			dispBlank <= blankEn_q && idleHit && !anyPress &&
				(state_q == NORMAL);
			configActive <= (state_q != NORMAL);
		end
	end

endmodule // pcm_menu_ctrl

// ==== bench/pcm_menu_props.sv ====
`timescale 1ns/10ps
`include "pcm_consts.vh"
module pcm_menu_props (
	input wire clock,
	input wire reset_n,
	input wire buttonRaw,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire [3:0] dispCode,
	input wire [2:0] dispItem,
	input wire [17:0] dispValue,
	input wire [1:0] dispDigit,
	input wire dispBlank,
	input wire configActive,
	input wire [7:0] busAddress,
	input wire [17:0] locationLabel,
	input wire nvCommit,
	input wire [15:0] nvZeroValue,
	input wire calUnreliable
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	property p_answer; psel && !penable |=> pready; endproperty
	property p_once; pready |=> !pready; endproperty
	property p_err; pslverr |-> pready; endproperty
	property p_range; busAddress >= 8'h01 && busAddress <= 8'hF7; endproperty
	property p_pulse; nvCommit |=> !nvCommit; endproperty
	property p_blank; $rose(dispBlank) |-> !configActive; endproperty
	property p_top; dispCode == `PCM_ST_TOP |-> dispItem <= `PCM_TOP_LAST;
	endproperty
	property p_bus; dispCode == `PCM_ST_BUS |-> dispItem <= `PCM_BUS_LAST;
	endproperty
	property p_digit;
		dispCode == `PCM_ST_ADDR_EDIT |-> dispDigit <= 2'h2 &&
			dispValue[5:0] <= 6'h09 && dispValue[11:6] <= 6'h09 &&
			dispValue[17:12] <= 6'h09;
	endproperty
	property p_hold;
		dispCode == `PCM_ST_HOLD |=> dispCode inside
			{`PCM_ST_HOLD, `PCM_ST_TOP, `PCM_ST_NORMAL};
	endproperty
	a_answer: assert property (p_answer)
		else $error("pready missing after setup");
	a_once: assert property (p_once)
		else $error("pready longer than one cycle");
	a_err: assert property (p_err)
		else $error("pslverr without pready");
	a_range: assert property (p_range)
		else $error("station address out of range");
	a_pulse: assert property (p_pulse)
		else $error("commit pulse too long");
	a_blank: assert property (p_blank)
		else $error("blanking inside configuration");
	a_top: assert property (p_top)
		else $error("top item index too large");
	a_bus: assert property (p_bus)
		else $error("bus item index too large");
	a_digit: assert property (p_digit)
		else $error("edit digit out of range");
	a_hold: assert property (p_hold)
		else $error("bad exit from hold prompt");
	c_hold: cover property (dispCode == `PCM_ST_HOLD);
	c_done: cover property (dispCode == `PCM_ST_ADDR_DONE);
	c_commit: cover property (nvCommit);
endmodule // pcm_menu_props

bind pcm_menu_ctrl pcm_menu_props pcm_menu_props_i (.clock(clock),
	.reset_n(reset_n), .buttonRaw(buttonRaw), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.dispCode(dispCode), .dispItem(dispItem), .dispValue(dispValue),
	.dispDigit(dispDigit), .dispBlank(dispBlank),
	.configActive(configActive), .busAddress(busAddress),
	.locationLabel(locationLabel), .nvCommit(nvCommit),
	.nvZeroValue(nvZeroValue), .calUnreliable(calUnreliable));

// ==== bench/tb_top.sv ====
`timescale 1ns/10ps
`include "pcm_consts.vh"
module tb_top;
	localparam IDLE = 200;
	logic clock = 0;
	logic reset_n = 0;
	logic buttonRaw = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	wire [31:0] prdata;
	wire pready, pslverr, dispBlank, configActive, nvCommit, calUnreliable;
	wire [3:0] dispCode;
	wire [2:0] dispItem;
	wire [17:0] dispValue, locationLabel;
	wire [1:0] dispDigit;
	wire [7:0] busAddress;
	wire [15:0] nvZeroValue;
	int err_total = 0;
	int check_count = 0;
	int cycles = 0;
	int commits = 0;
	logic [31:0] rd;
	logic er, seenA, seenB;

	pcm_menu_ctrl #(.DEB_CYC(4), .LONG_CYC(20), .IDLE_CYC(IDLE),
		.ALT_CYC(10)) pcm_menu_ctrl_i (.clock(clock), .reset_n(reset_n),
		.buttonRaw(buttonRaw), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .dispCode(dispCode),
		.dispItem(dispItem), .dispValue(dispValue), .dispDigit(dispDigit),
		.dispBlank(dispBlank), .configActive(configActive),
		.busAddress(busAddress), .locationLabel(locationLabel),
		.nvCommit(nvCommit), .nvZeroValue(nvZeroValue),
		.calUnreliable(calUnreliable));

	initial begin
		forever #50 clock = ~clock;
	end

	always @(posedge clock) begin
		cycles = cycles + 1;
		if (nvCommit === 1'b1)
			commits = commits + 1;
		if (cycles == 20000) begin
			err_total = err_total + 1;
			wrap_up();
		end
	end

	task wrap_up;
		if (err_total == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count = check_count + 1;
		if (got !== exp) begin
			err_total = err_total + 1;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task st(input logic [3:0] c, input logic [2:0] i);
		chk({dispCode, dispItem}, {c, i});
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clock);
	endtask

	// Short press is held 8 cycles, long press 30, then 30 idle cycles
	task press(input int n, input logic lng);
		repeat (n) begin
			@(posedge clock);
			buttonRaw <= 1;
			repeat (lng ? 30 : 8) @(posedge clock);
			buttonRaw <= 0;
			repeat (30) @(posedge clock);
		end
	endtask

	initial begin
		repeat (12) @(posedge clock);
		reset_n <= 1;
		@(posedge clock);
		chk(busAddress, 32'h1);
		apb(0, 8'h18, 32'h0);
		chk(er, 32'h1);
		chk(rd, 32'h0);
		press(1, 0);
		st(`PCM_ST_NORMAL, 3'h0);
		@(posedge clock);
		buttonRaw <= 1;
		repeat (30) @(posedge clock);
		chk(dispCode, `PCM_ST_HOLD);
		buttonRaw <= 0;
		repeat (30) @(posedge clock);
		st(`PCM_ST_TOP, 3'h0);
		for (int i = 1; i <= 7; i++) begin
			press(1, 0);
			st(`PCM_ST_TOP, 3'(i % 7));
		end
		press(1, 0);
		press(1, 1);
		st(`PCM_ST_BUS, 3'h0);
		press(1, 0);
		press(1, 1);
		chk(dispCode, `PCM_ST_ADDR_SHOW);
		chk(dispValue, 32'h1);
		press(1, 0);
		st(`PCM_ST_BUS, 3'h1);
		press(2, 1);
		chk({dispCode, dispDigit}, {`PCM_ST_ADDR_EDIT, 2'h0});
		press(9, 0);
		chk(dispValue[5:0], 32'h0);
		press(1, 1);
		chk(dispDigit, 32'h1);
		press(2, 0);
		press(1, 1);
		press(1, 0);
		press(1, 1);
		chk(dispValue, 32'h1080);
		chk(busAddress, 32'h78);
		press(1, 0);
		st(`PCM_ST_BUS, 3'h1);
		press(2, 1);
		press(8, 0);
		press(1, 1);
		press(2, 0);
		press(1, 1);
		press(1, 0);
		press(1, 1);
		chk({dispCode, dispValue}, {`PCM_ST_ADDR_DONE, 18'h02108});
		chk(busAddress, 32'h78);
		press(2, 0);
		press(1, 1);
		st(`PCM_ST_TOP, 3'h1);
		press(2, 0);
		press(1, 1);
		st(`PCM_ST_XMT, 3'h0);
		press(1, 0);
		press(1, 1);
		apb(0, `PCM_OFF_CTRL, 32'h0);
		chk(rd & 32'h1, 32'h1);
		press(1, 0);
		press(1, 1);
		chk(dispCode, `PCM_ST_LBL_EDIT);
		press(1, 0);
		press(3, 1);
		chk(locationLabel, 32'h1);
		press(2, 0);
		press(1, 1);
		st(`PCM_ST_TOP, 3'h3);
		press(4, 0);
		press(1, 1);
		st(`PCM_ST_NORMAL, 3'h0);
		repeat (IDLE) @(posedge clock);
		chk(dispBlank, 32'h1);
		press(1, 0);
		chk(dispBlank, 32'h0);
		press(1, 1);
		press(1, 0);
		press(1, 1);
		press(1, 0);
		press(2, 1);
		press(1, 0);
		repeat (IDLE + 20) @(posedge clock);
		chk({configActive, dispCode}, {1'b1, `PCM_ST_BUS});
		repeat (4 * IDLE) @(posedge clock);
		chk(dispCode, `PCM_ST_NORMAL);
		chk(busAddress, 32'h78);
		apb(1, `PCM_OFF_CTRL, 32'h6);
		seenA = 0;
		seenB = 0;
		repeat (60) begin
			@(posedge clock);
			if (dispCode === `PCM_DISP_CAL)
				seenA = 1;
			if (dispCode === `PCM_DISP_SER)
				seenB = 1;
		end
		chk({seenA, seenB}, 32'h3);
		apb(1, `PCM_OFF_CAL, 32'h12340001);
		chk(nvZeroValue, 32'h0);
		apb(0, `PCM_OFF_CAL, 32'h0);
		chk(rd, 32'h12340001);
		apb(1, `PCM_OFF_CAL, 32'h4);
		chk(calUnreliable, 32'h1);
		apb(1, `PCM_OFF_CAL, 32'h2);
		repeat (3) @(posedge clock);
		chk({calUnreliable, nvZeroValue}, 32'h1234);
		chk(commits, 32'h1);
		apb(1, `PCM_OFF_ADDR, 32'hF8);
		apb(0, `PCM_OFF_ADDR, 32'h0);
		chk(rd, 32'h78);
		apb(1, `PCM_OFF_ADDR, 32'hC8);
		apb(0, `PCM_OFF_ADDR, 32'h0);
		chk(rd, 32'hC8);
		wrap_up();
	end
endmodule // tb_top
